// file: rtl/column_clock_reset_and_io_cells.v
// Column clock and reset distribution with perimeter I/O cell control, APB configured
//
// Function
// RULE1: per-column clock mux, four sources
// RULE2: columns clocked independently, global clock low-skew
// RULE3: constant-1 clock gives column no edges
// RULE4: global clock feeds both upper corners
// RULE5: per-column reset mux, four sources
// RULE6: constant-1 reset never resets column
// RULE7: global reset feeds both lower corners
// RULE8: power-up resets all array registers
// RULE9: A pin: exit A drives, input feeds entrance A
// RULE10: B pins use B ports; types alternate
// RULE11: output enable from four choices
// RULE12: outputs never drive after power-up
// RULE13: optional registering of pin in and out
// RULE14: entrance/exit edge ports meet express buses
// RULE15: untouched array parts keep running on reconfig
// RULE16: array registers use rising column clock edge
// RULE17: global reset asynchronous, config never touches it; here global_rst_pin_n passes two pclk flops and a register before any column
// RULE18: selectors held static in configuration memory
`timescale 1ns/1ns
`include "col_ctl_map.vh"
module column_clock_reset_and_io_cells (
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Global pins
    input wire global_clk_pin,
    input wire global_rst_pin_n,
    // Per-column sources from the array
    input wire [`NUM_COLS-1:0] xbus_clk_in,
    input wire [`NUM_COLS-1:0] head_cell_a_out,
    input wire [`NUM_COLS-1:0] xbus_rst_in,
    input wire [`NUM_COLS-1:0] foot_cell_a_out,
    // Column clock level, rising-edge strobe and active-low reset
    output reg [`NUM_COLS-1:0] col_clk_r,
    output reg [`NUM_COLS-1:0] col_tick_r,
    output reg [`NUM_COLS-1:0] col_rst_n_r,
    // Corner cell A inputs
    output reg upper_left_corner_in,
    output reg upper_right_corner_in,
    output reg lower_left_corner_in,
    output reg lower_right_corner_in,
    // I/O pins (three-signal form)
    input wire [`NUM_PINS-1:0] pin_in,
    output reg [`NUM_PINS-1:0] pin_out,
    output reg [`NUM_PINS-1:0] pin_oe,
    // Exit cell edge-facing outputs and output-cell local buses
    input wire [`NUM_PINS-1:0] exit_cell_a_out,
    input wire [`NUM_PINS-1:0] exit_cell_b_out,
    input wire [`NUM_PINS-1:0] out_cell_vbus,
    input wire [`NUM_PINS-1:0] out_cell_hbus,
    // Entrance cell edge-facing inputs
    output reg [`NUM_PINS-1:0] entr_cell_a_in,
    output reg [`NUM_PINS-1:0] entr_cell_b_in,
    // Entrance cell edge-facing outputs onto express buses
    input wire [`NUM_PINS-1:0] entr_cell_a_out,
    input wire [`NUM_PINS-1:0] entr_cell_b_out,
    output reg [`NUM_PINS-1:0] xbus_a_drive,
    output reg [`NUM_PINS-1:0] xbus_b_drive,
    // Express buses into exit cell edge-facing inputs
    input wire [`NUM_PINS-1:0] xbus_a_in,
    input wire [`NUM_PINS-1:0] xbus_b_in,
    output reg [`NUM_PINS-1:0] exit_cell_a_in,
    output reg [`NUM_PINS-1:0] exit_cell_b_in
);
    // Configuration memory
    reg [15:0] clk_sel_r;
    reg [15:0] rst_sel_r;
    reg [15:0] oe_sel_r;
    reg [15:0] io_reg_r;

    wire gclk_s;
    wire grst_n_s;
    wire [`NUM_PINS-1:0] pin_in_s;

    reg [`NUM_COLS-1:0] clk_src;
    reg [`NUM_COLS-1:0] rst_src_n;
    reg [`NUM_PINS-1:0] out_src;
    reg [`NUM_PINS-1:0] oe_src;
    reg [`NUM_PINS-1:0] pin_out_nxt;
    reg [`NUM_PINS-1:0] in_hold_r;
    reg [`NUM_PINS-1:0] out_hold_r;
    reg [`NUM_PINS-1:0] in_val;
    reg [`NUM_PINS-1:0] entr_a_nxt;
    reg [`NUM_PINS-1:0] entr_b_nxt;
    reg [31:0] rdata_nxt;
    reg addr_ok;
    integer ci;
    integer pi;

    wire acc_start = psel & penable & ~pready;
    wire acc_done = psel & penable & pready;

    function sel4;
        input [1:0] sel;
        input src_global;
        input src_express;
        input src_cell;
        begin
            case (sel)
                `SEL_GLOBAL: sel4 = src_global;
                `SEL_EXPRESS: sel4 = src_express;
                `SEL_CELL_A: sel4 = src_cell;
                default: sel4 = 1'b1;
            endcase
        end
    endfunction

    // A completed APB write to one word
    function wr_hit;
        input done;
        input wr;
        input [11:0] addr;
        input [11:0] off;
        begin
            wr_hit = done & wr & (addr == off);
        end
    endfunction

    // Pins alternate in type around the edge: even A-type, odd B-type
    function pin_is_a;
        input integer idx;
        begin
            pin_is_a = (idx % 2 == 0);
        end
    endfunction

    // Pins are asynchronous to pclk and pass two flops first
    sync2 #(.W(2)) u_gsync (
        .pclk(pclk),
        .presetn(presetn),
        .d({global_clk_pin, global_rst_pin_n}),
        .q({gclk_s, grst_n_s})
    );

    sync2 #(.W(`NUM_PINS)) u_psync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pin_in),
        .q(pin_in_s)
    );

    // Register decode
    always @* begin
        addr_ok = 1'b1;
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            `OFF_CLK_SEL: rdata_nxt = {16'h0000, clk_sel_r};
            `OFF_RST_SEL: rdata_nxt = {16'h0000, rst_sel_r};
            `OFF_OE_SEL: rdata_nxt = {16'h0000, oe_sel_r};
            `OFF_IO_REG: rdata_nxt = {16'h0000, io_reg_r};
            `OFF_STATUS: rdata_nxt = {16'h0000, ~col_rst_n_r, col_clk_r};
            default: addr_ok = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= acc_start;
        end
    end

    // Answer data and error stand only while pready is high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            if (acc_start) begin
                pslverr <= ~addr_ok;
                prdata <= (pwrite | ~addr_ok) ? 32'h0000_0000 : rdata_nxt;
            end else if (acc_done) begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Each selector word has its own write, so every other column and pin runs on [RULE15]
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sel_r <= `CLK_SEL_RST;
        end else if (wr_hit(acc_done, pwrite, paddr, `OFF_CLK_SEL)) begin
            clk_sel_r <= pwdata[15:0]; // [RULE18]
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_sel_r <= `RST_SEL_RST;
        end else if (wr_hit(acc_done, pwrite, paddr, `OFF_RST_SEL)) begin
            rst_sel_r <= pwdata[15:0]; // [RULE18]
        end
    end

    // Power-up leaves every driver off until software picks a source
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_sel_r <= `OE_SEL_RST; // [RULE12]
        end else if (wr_hit(acc_done, pwrite, paddr, `OFF_OE_SEL)) begin
            oe_sel_r <= pwdata[15:0]; // [RULE18]
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_reg_r <= `IO_REG_RST;
        end else if (wr_hit(acc_done, pwrite, paddr, `OFF_IO_REG)) begin
            io_reg_r <= pwdata[15:0]; // [RULE13]
        end
    end

    // Column source selection
    always @* begin
        for (ci = 0; ci < `NUM_COLS; ci = ci + 1) begin
            clk_src[ci] = sel4(clk_sel_r[2*ci +: 2], gclk_s, xbus_clk_in[ci], head_cell_a_out[ci]); // [RULE1] [RULE2]
            rst_src_n[ci] = sel4(rst_sel_r[2*ci +: 2], grst_n_s, xbus_rst_in[ci], foot_cell_a_out[ci]); // [RULE5]
        end
    end

    // A held-high source never shows a rising edge, so the tick stays quiet
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col_clk_r <= {`NUM_COLS{1'b1}};
            col_tick_r <= {`NUM_COLS{1'b0}};
        end else begin
            col_clk_r <= clk_src;
            col_tick_r <= clk_src & ~col_clk_r; // [RULE3] [RULE16]
        end
    end

    // Power-up holds every column in reset, whatever its selection
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col_rst_n_r <= {`NUM_COLS{1'b0}}; // [RULE8]
        end else begin
            col_rst_n_r <= rst_src_n; // [RULE6] [RULE17]
        end
    end

    // Upper corner cells see the global clock directly, bypassing the column muxes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_left_corner_in <= 1'b0;
            upper_right_corner_in <= 1'b0;
        end else begin
            upper_left_corner_in <= gclk_s; // [RULE4]
            upper_right_corner_in <= gclk_s; // [RULE4]
        end
    end

    // The lower corners see the global reset the same way
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lower_left_corner_in <= 1'b0;
            lower_right_corner_in <= 1'b0;
        end else begin
            lower_left_corner_in <= grst_n_s; // [RULE7]
            lower_right_corner_in <= grst_n_s; // [RULE7]
        end
    end

    // Even pins are A-type, odd pins B-type
    always @* begin
        for (pi = 0; pi < `NUM_PINS; pi = pi + 1) begin
            out_src[pi] = pin_is_a(pi) ? exit_cell_a_out[pi] : exit_cell_b_out[pi]; // [RULE9] [RULE10]
            in_val[pi] = io_reg_r[`IO_REG_IN_LSB + pi] ? in_hold_r[pi] : pin_in_s[pi]; // [RULE13]
            pin_out_nxt[pi] = io_reg_r[`IO_REG_OUT_LSB + pi] ? out_hold_r[pi] : out_src[pi]; // [RULE13]
            entr_a_nxt[pi] = pin_is_a(pi) ? in_val[pi] : 1'b0; // [RULE9]
            entr_b_nxt[pi] = pin_is_a(pi) ? 1'b0 : in_val[pi]; // [RULE10]
            case (oe_sel_r[2*pi +: 2])
                `OE_ALWAYS: oe_src[pi] = 1'b1; // [RULE11]
                `OE_NEVER: oe_src[pi] = 1'b0;
                `OE_VBUS: oe_src[pi] = ~out_cell_vbus[pi]; // [RULE11]
                default: oe_src[pi] = ~out_cell_hbus[pi]; // [RULE11]
            endcase
        end
    end

    // Registered mode adds one stage by sampling only on the column-0 tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_hold_r <= {`NUM_PINS{1'b0}};
            out_hold_r <= {`NUM_PINS{1'b0}};
        end else if (col_tick_r[0]) begin
            in_hold_r <= pin_in_s; // [RULE13]
            out_hold_r <= out_src; // [RULE13]
        end
    end

    // Drivers stay off through reset whatever the enable selection
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= {`NUM_PINS{1'b0}};
            pin_oe <= {`NUM_PINS{1'b0}}; // [RULE12]
        end else begin
            pin_out <= pin_out_nxt;
            pin_oe <= oe_src;
        end
    end

    // The entrance port of the other pin type is held low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entr_cell_a_in <= {`NUM_PINS{1'b0}};
            entr_cell_b_in <= {`NUM_PINS{1'b0}};
        end else begin
            entr_cell_a_in <= entr_a_nxt;
            entr_cell_b_in <= entr_b_nxt;
        end
    end

    // Entrance cells drive the perpendicular express buses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xbus_a_drive <= {`NUM_PINS{1'b0}};
            xbus_b_drive <= {`NUM_PINS{1'b0}};
        end else begin
            xbus_a_drive <= entr_cell_a_out; // [RULE14]
            xbus_b_drive <= entr_cell_b_out; // [RULE14]
        end
    end

    // Exit cells take their edge-facing inputs from the same buses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exit_cell_a_in <= {`NUM_PINS{1'b0}};
            exit_cell_b_in <= {`NUM_PINS{1'b0}};
        end else begin
            exit_cell_a_in <= xbus_a_in; // [RULE14]
            exit_cell_b_in <= xbus_b_in; // [RULE14]
        end
    end
endmodule // column_clock_reset_and_io_cells

// file: rtl/col_ctl_map.vh
// Register offsets, field layouts and reset values of the column clock/reset and I/O control block
`ifndef COL_CTL_MAP_VH
`define COL_CTL_MAP_VH

`define NUM_COLS 8
`define NUM_PINS 8

`define OFF_CLK_SEL 12'h000
`define OFF_RST_SEL 12'h004
`define OFF_OE_SEL 12'h008
`define OFF_IO_REG 12'h00c
`define OFF_STATUS 12'h010

// Two-bit selector codes for column clock and column reset
`define SEL_GLOBAL 2'h0
`define SEL_EXPRESS 2'h1
`define SEL_CELL_A 2'h2
`define SEL_CONST1 2'h3

// Two-bit output-enable selector codes
`define OE_ALWAYS 2'h0
`define OE_NEVER 2'h1
`define OE_VBUS 2'h2
`define OE_HBUS 2'h3

`define CLK_SEL_RST 16'hffff
`define RST_SEL_RST 16'hffff
`define OE_SEL_RST 16'h5555
`define IO_REG_RST 16'h0000

`define IO_REG_IN_LSB 0
`define IO_REG_OUT_LSB 8
`define STATUS_CLK_LSB 0
`define STATUS_RST_LSB 8

`endif

// file: rtl/sync2.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sync2 #(
    parameter W = 1
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;

    // Only the second flop is ever read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // sync2

// file: bench/col_ctl_monitor.sv
// Port-level assertions for the column clock/reset block
`timescale 1ns/1ns
module col_ctl_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire [7:0] col_clk_r,
    input wire [7:0] col_tick_r,
    input wire [7:0] col_rst_n_r,
    input wire [7:0] pin_oe,
    input wire upper_left_corner_in,
    input wire upper_right_corner_in,
    input wire lower_left_corner_in,
    input wire lower_right_corner_in
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_tick; col_tick_r == (col_tick_r & col_clk_r & ~$past(col_clk_r)); endproperty
    a_tick: assert property (p_tick) else $error("tick without clock rise");
    property p_up; upper_left_corner_in == upper_right_corner_in; endproperty
    a_up: assert property (p_up) else $error("upper corners differ");
    property p_low; lower_left_corner_in == lower_right_corner_in; endproperty
    a_low: assert property (p_low) else $error("lower corners differ");
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("no answer after one wait");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_err; pslverr |-> pready && psel && penable; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_oe0; $rose(presetn) |-> (pin_oe == 8'h00) [*2]; endproperty
    a_oe0: assert property (p_oe0) else $error("driver on after power-up");
    property p_rst0; $rose(presetn) |-> col_rst_n_r == 8'h00; endproperty
    a_rst0: assert property (p_rst0) else $error("column not reset at power-up");
endmodule // col_ctl_monitor

// file: bench/ext_pin_model.sv
// Global clock and reset pin sources outside the device
`timescale 1ns/1ns
module ext_pin_model (
    input wire pclk,
    input wire clk_run,
    input wire rst_req,
    output logic global_clk_pin,
    output logic global_rst_pin_n
);
    initial begin
        global_clk_pin = 1'b0;
        global_rst_pin_n = 1'b1;
    end
    // Clock stands still unless asked to run, so a stuck selector cannot hide behind it
    always @(posedge pclk) begin
        global_clk_pin <= clk_run ? ~global_clk_pin : global_clk_pin;
        global_rst_pin_n <= ~rst_req;
    end
endmodule // ext_pin_model

// file: bench/column_clock_reset_and_io_cells_tb_top.sv
// Self-checking bench for column clock/reset distribution and I/O cell control
`timescale 1ns/1ns
`include "col_ctl_map.vh"
module column_clock_reset_and_io_cells_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clk_run, rst_req, er;
    logic global_clk_pin, global_rst_pin_n;
    logic upper_left_corner_in, upper_right_corner_in, lower_left_corner_in, lower_right_corner_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] xbus_clk_in, head_cell_a_out, xbus_rst_in, foot_cell_a_out, col_clk_r, col_tick_r, col_rst_n_r;
    logic [7:0] pin_in, pin_out, pin_oe, exit_cell_a_out, exit_cell_b_out, out_cell_vbus, out_cell_hbus;
    logic [7:0] entr_cell_a_in, entr_cell_b_in, entr_cell_a_out, entr_cell_b_out, xbus_a_drive, xbus_b_drive;
    logic [7:0] xbus_a_in, xbus_b_in, exit_cell_a_in, exit_cell_b_in;
    int bad_count = 0;
    int samples_checked = 0;
    column_clock_reset_and_io_cells u_column_clock_reset_and_io_cells (.*);
    ext_pin_model u_ext_pin_model (.*);
    task automatic end_sim;
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
        if (pready !== 1'b1) begin
            bad_count++;
            end_sim;
        end
    endtask
    task automatic t_reset;
        apb(1'b0, `OFF_CLK_SEL, 32'h0);
        chk(rd, `CLK_SEL_RST);
        apb(1'b0, `OFF_OE_SEL, 32'h0);
        chk(rd, `OE_SEL_RST);
        chk({col_clk_r, col_rst_n_r, pin_oe}, 24'hffff00);
        apb(1'b1, 12'h014, 32'h1234);
        apb(1'b1, `OFF_STATUS, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk({rd[30:0], er}, 32'h1fe);
    endtask
    task automatic t_clk;
        int s, c0, c1;
        for (s = 0; s < 4; s++) begin
            apb(1'b1, `OFF_CLK_SEL, {16'h0, {7{s[1:0]}}, 2'h3});
            c0 = 0;
            c1 = 0;
            clk_run <= (s == 0);
            repeat (39) begin
                @(posedge pclk);
                xbus_clk_in <= xbus_clk_in ^ {8{s == 1}};
                head_cell_a_out <= head_cell_a_out ^ {8{s == 2}};
                c0 += col_tick_r[0];
                c1 += col_tick_r[1];
            end
            clk_run <= 1'b0;
            repeat (4) @(posedge pclk);
            chk(c0, 0);
            chk(c1 > 5, s != 3);
            chk(upper_left_corner_in, global_clk_pin);
        end
        chk(col_clk_r, 8'hff);
    endtask
    task automatic t_rst;
        int s;
        for (s = 0; s < 3; s++) begin
            apb(1'b1, `OFF_RST_SEL, {16'h0, {7{s[1:0]}}, 2'h3});
            rst_req <= (s == 0);
            xbus_rst_in <= {8{s != 1}};
            foot_cell_a_out <= {8{s != 2}};
            repeat (6) @(posedge pclk);
            chk({col_rst_n_r, 7'h0, lower_left_corner_in}, {8'h01, 8'(s != 0)});
            {rst_req, xbus_rst_in, foot_cell_a_out} <= 17'hffff;
            repeat (6) @(posedge pclk);
            chk(col_rst_n_r, 8'hff);
        end
    endtask
    task automatic t_io;
        apb(1'b1, `OFF_OE_SEL, 32'h0000e4e4);
        {out_cell_vbus, out_cell_hbus, exit_cell_a_out, exit_cell_b_out} <= 32'h00ff55aa;
        {pin_in, entr_cell_a_out, entr_cell_b_out, xbus_a_in, xbus_b_in} <= 40'h0f3c5a96c3;
        repeat (5) @(posedge pclk);
        chk({pin_oe, pin_out}, 16'h55ff);
        chk({entr_cell_b_in, entr_cell_a_in}, 16'h0a05);
        chk({xbus_a_drive, xbus_b_drive, exit_cell_a_in, exit_cell_b_in}, 32'h3c5a96c3);
        {out_cell_vbus, out_cell_hbus, exit_cell_a_out, exit_cell_b_out, pin_in} <= 40'hff0055aaf0;
        apb(1'b1, `OFF_IO_REG, 32'h0000ffff);
        apb(1'b1, `OFF_CLK_SEL, 32'h0000fffd);
        apb(1'b0, `OFF_CLK_SEL, 32'h0);
        chk(rd, 32'h0000fffd);
        repeat (6) begin
            @(posedge pclk);
            xbus_clk_in <= ~xbus_clk_in;
        end
        repeat (4) @(posedge pclk);
        {exit_cell_a_out, exit_cell_b_out, pin_in} <= 24'haa550f;
        repeat (5) @(posedge pclk);
        chk({pin_oe, pin_out}, 16'h99ff);
        chk({entr_cell_b_in, entr_cell_a_in}, 16'ha050);
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, clk_run, rst_req, paddr, pwdata} = '0;
        {xbus_clk_in, head_cell_a_out, pin_in, exit_cell_a_out, exit_cell_b_out} = '0;
        {out_cell_vbus, out_cell_hbus, entr_cell_a_out, entr_cell_b_out, xbus_a_in, xbus_b_in} = '0;
        {xbus_rst_in, foot_cell_a_out} = 16'hffff;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_clk;
        t_rst;
        t_io;
        end_sim;
    end
endmodule // column_clock_reset_and_io_cells_tb_top
bind column_clock_reset_and_io_cells col_ctl_monitor u_col_ctl_monitor (.*);
